// *** rtl/alc_defs.svh ***
// constants for the ambient light conversion timing block
// assumes a 100 ns system clock; included by alc_pkg and the testbench
`ifndef ALC_DEFS_SVH
`define ALC_DEFS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define ALC_CLK_NS 100
`define ALC_FRAME_MS 100
`define ALC_CONV_US 300
`define ALC_FRAME_CYC (`ALC_FRAME_MS * 1000000 / `ALC_CLK_NS)
`define ALC_CONV_CYC (`ALC_CONV_US * 1000 / `ALC_CLK_NS)
// ----------------------------------------
// serial bus and pointer map
// ----------------------------------------
`define ALC_DEV_ADDR 7'h13
`define ALC_PTR_HI 8'h85
`define ALC_PTR_LO 8'h86
`define ALC_PTR_RST 8'h00
`define ALC_RD_IDLE 8'h00
`define ALC_RES_W 16
`define ALC_AVG_W 3
`endif

// *** rtl/alc_pkg.sv ***
// types shared by the light conversion block
// assumes alc_defs.svh is on the include path
package alc_pkg;
  `include "alc_defs.svh"
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_WDATA, I_WACK, I_RDATA, I_RACK} alc_bus_st_t;
  typedef enum logic {E_CONV, E_HOLD} alc_eng_st_t;
  typedef struct packed {
    logic cont;
    logic [`ALC_AVG_W-1:0] code;
  } alc_cfg_t;
  typedef struct packed {
    logic valid;
    logic [`ALC_RES_W-1:0] value;
  } alc_res_t;
endpackage

// *** rtl/alc_conv_engine.sv ***
// conversion sequencer: times single conversions, averages, publishes
// assumes sample is stable from the front end on the same clock
module alc_conv_engine import alc_pkg::*; #(
  parameter int unsigned FRAME_CYC = `ALC_FRAME_CYC
) (
  input logic clk,
  input logic rst,
  input alc_cfg_t cfg,
  input logic [`ALC_RES_W-1:0] sample,
  output alc_res_t res,
  output logic busy
);
  localparam int unsigned CONV_CYC = `ALC_CONV_CYC;
  localparam int FW = $clog2(FRAME_CYC);
  localparam int CW = $clog2(CONV_CYC);
  localparam int AW = `ALC_RES_W + 7;

  alc_eng_st_t st_ff;
  logic [FW-1:0] frame_ff;
  logic [CW-1:0] conv_ff;
  logic [6:0] num_ff;
  logic [AW-1:0] acc_ff;
  logic [AW-1:0] nxt_acc;
  logic [2:0] code_ff;
  logic cont_ff;
  logic busy_ff;
  alc_res_t res_ff;
  logic conv_end;
  logic last;
  logic frame_end;

  assign conv_end = (st_ff == E_CONV) && (conv_ff == CW'(CONV_CYC - 1));
  assign last = num_ff == 7'((8'h01 << code_ff) - 8'h01);
  assign frame_end = frame_ff == FW'(FRAME_CYC - 1);
  assign nxt_acc = acc_ff + AW'(sample);
  assign res = res_ff;
  assign busy = busy_ff;

  // ----------------------------------------
  // frame and conversion counters
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst || cont_ff || frame_end) begin
      frame_ff <= '0; // R4
    end else begin
      frame_ff <= FW'(frame_ff + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || conv_end || st_ff != E_CONV) begin
      conv_ff <= '0; // R5
    end else begin
      conv_ff <= CW'(conv_ff + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    busy_ff <= !rst && (st_ff == E_CONV);
  end

  // ----------------------------------------
  // averaging batch
  // ----------------------------------------
  always_ff @(posedge clk) begin
    res_ff.valid <= 1'b0;
    if (rst) begin
      st_ff <= E_CONV;
      num_ff <= '0;
      acc_ff <= '0;
      code_ff <= '0;
      cont_ff <= 1'b0;
      res_ff <= '0;
    end else begin
      case (st_ff)
        E_CONV: begin
          // settings are taken once per batch so a result never mixes counts
          if (conv_ff == '0 && num_ff == '0) begin
            code_ff <= cfg.code; // R6
            cont_ff <= cfg.cont;
          end
          if (conv_end) begin
            if (!last) begin
              acc_ff <= nxt_acc; // R9
              num_ff <= 7'(num_ff + 1'b1);
            end else if (cont_ff) begin
              res_ff.value <= `ALC_RES_W'(nxt_acc >> code_ff); // R12
              res_ff.valid <= 1'b1;
              acc_ff <= '0;
              num_ff <= '0;
            end else begin
              acc_ff <= nxt_acc;
              st_ff <= E_HOLD;
            end
          end
        end
        E_HOLD: begin
          if (frame_end) begin
            res_ff.value <= `ALC_RES_W'(acc_ff >> code_ff); // R7 R8
            res_ff.valid <= 1'b1;
            acc_ff <= '0;
            num_ff <= '0;
            st_ff <= E_CONV;
          end
        end
        default: st_ff <= E_CONV;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_no_gap;
    conv_end && !last |=> st_ff == E_CONV && conv_ff == '0 ##1 conv_ff == CW'(1);
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("gap between conversions"); // R9
  property p_cont_pub;
    conv_end && last && cont_ff |=> res_ff.valid;
  endproperty
  a_cont_pub: assert property (p_cont_pub) else $error("continuous result late"); // R12
  property p_std_edge;
    res_ff.valid && !cont_ff |-> frame_ff == '0;
  endproperty
  a_std_edge: assert property (p_std_edge) else $error("result off frame edge"); // R8
  property p_hold;
    st_ff == E_HOLD && !frame_end |=> st_ff == E_HOLD && !res_ff.valid;
  endproperty
  a_hold: assert property (p_hold) else $error("frame left early"); // R4
  property p_conv_len;
    st_ff == E_CONV |-> conv_ff < CW'(CONV_CYC);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion overlong"); // R5
  property p_mean;
    st_ff == E_HOLD && frame_end |=> res_ff.value == `ALC_RES_W'($past(acc_ff) >> code_ff);
  endproperty
  a_mean: assert property (p_mean) else $error("result is not the mean"); // R7
  c_avg128: cover property (conv_end && last && code_ff == 3'h7);
  c_std_pub: cover property (res_ff.valid && !cont_ff);
endmodule

// *** rtl/alc_light_timing.sv ***
// ambient light result path: serial slave with pointer plus conversion timing
// assumes SCL and SDA arrive unsynchronised; the pad resolves SDA from SDA_OE_N
//
// Contract
// [R1] host sets the pointer by writing 85h to write address 26h, no data
// [R2] after pointer set, a read at 27h returns the result high byte
// [R3] a following read without re-addressing returns the low byte from 86h
// [R4] standard mode runs each measurement inside a fixed 100 ms frame
// [R5] each single conversion lasts about 300 us; rest of frame idle
// [R6] averaging count selectable up to 128 conversions per result
// [R7] reported value is the mean of the configured conversions
// [R8] standard mode publishes only after the 100 ms frame elapses
// [R9] continuous mode starts each conversion right after the previous ends
// [R10] pointer increments after each byte read
// [R11] stop or repeated start between pointer write and read both accepted
// [R12] continuous mode publishes as soon as the last conversion completes
module alc_light_timing import alc_pkg::*; #(
  parameter int unsigned FRAME_CYC = `ALC_FRAME_CYC
) (
  input logic CLOCK,
  input logic RST,
  input logic SCL_I,
  input logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  input logic CONT_MODE,
  input logic [`ALC_AVG_W-1:0] AVG_CODE,
  input logic [`ALC_RES_W-1:0] ALS_SAMPLE,
  output logic CONV_ACTIVE
);
  alc_bus_st_t st_ff;
  logic [2:0] scl_s_ff;
  logic [2:0] sda_s_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff;
  logic [7:0] tx_ff;
  logic [7:0] ptr_ff;
  logic [7:0] lo_hold_ff;
  logic [15:0] res_ff;
  logic rw_ff;
  logic ack_ff;
  logic first_ff;
  logic oe_n_ff;
  logic sda_o_ff;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [7:0] rd_b;
  alc_cfg_t cfg;
  alc_res_t eng_res;

  // ----------------------------------------
  // conversion engine
  // ----------------------------------------
  assign cfg.cont = CONT_MODE;
  assign cfg.code = AVG_CODE;

  alc_conv_engine #(
    .FRAME_CYC(FRAME_CYC)
  ) u_eng (
    .clk(CLOCK),
    .rst(RST),
    .cfg(cfg),
    .sample(ALS_SAMPLE),
    .res(eng_res),
    .busy(CONV_ACTIVE)
  );

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      res_ff <= '0;
    end else if (eng_res.valid) begin
      res_ff <= eng_res.value;
    end
  end

  // ----------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      scl_s_ff <= 3'h7;
      sda_s_ff <= 3'h7;
    end else begin
      scl_s_ff <= {scl_s_ff[1:0], SCL_I};
      sda_s_ff <= {sda_s_ff[1:0], SDA_I};
    end
  end

  assign scl = scl_s_ff[1];
  assign sda = sda_s_ff[1];
  assign rise = scl && !scl_s_ff[2];
  assign fall = !scl && scl_s_ff[2];
  assign start = scl && scl_s_ff[2] && !sda && sda_s_ff[2];
  assign stop = scl && scl_s_ff[2] && sda && !sda_s_ff[2];

  // ----------------------------------------
  // read data selection
  // ----------------------------------------
  // low byte comes from a copy taken with the high byte, so a result
  // landing between the two reads cannot tear the pair
  function automatic logic [7:0] rd_sel(input logic [7:0] ptr, input logic [15:0] res,
                                        input logic [7:0] lo);
    if (ptr == `ALC_PTR_HI) begin
      rd_sel = res[15:8];
    end else if (ptr == `ALC_PTR_LO) begin
      rd_sel = lo;
    end else begin
      rd_sel = `ALC_RD_IDLE;
    end
  endfunction

  assign rd_b = rd_sel(ptr_ff, res_ff, lo_hold_ff);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      lo_hold_ff <= '0;
    end else if (fall && ptr_ff == `ALC_PTR_HI && (st_ff == I_AACK || st_ff == I_RACK)) begin
      lo_hold_ff <= res_ff[7:0];
    end
  end

  // ----------------------------------------
  // serial slave
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    sda_o_ff <= 1'b0;
    if (RST) begin
      st_ff <= I_IDLE;
      cnt_ff <= '0;
      sh_ff <= '0;
      tx_ff <= 8'hFF;
      ptr_ff <= `ALC_PTR_RST;
      rw_ff <= 1'b0;
      ack_ff <= 1'b0;
      first_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else if (start) begin
      st_ff <= I_ADDR; // R11
      cnt_ff <= '0;
      oe_n_ff <= 1'b1;
    end else if (stop) begin
      st_ff <= I_IDLE; // R11
      oe_n_ff <= 1'b1;
    end else begin
      case (st_ff)
        I_ADDR, I_WDATA: begin
          if (rise) begin
            sh_ff <= {sh_ff[6:0], sda};
            cnt_ff <= 4'(cnt_ff + 1'b1);
          end else if (fall && cnt_ff == 4'h8) begin
            cnt_ff <= '0;
            if (st_ff == I_WDATA) begin
              oe_n_ff <= 1'b0;
              st_ff <= I_WACK;
              first_ff <= 1'b0;
              if (first_ff) begin
                ptr_ff <= sh_ff; // R1
              end
            end else if (sh_ff[7:1] == `ALC_DEV_ADDR) begin
              oe_n_ff <= 1'b0;
              rw_ff <= sh_ff[0];
              first_ff <= !sh_ff[0];
              st_ff <= I_AACK;
            end else begin
              st_ff <= I_IDLE;
            end
          end
        end
        I_WACK: begin
          if (fall) begin
            oe_n_ff <= 1'b1;
            st_ff <= I_WDATA;
          end
        end
        I_AACK, I_RACK: begin
          if (rise) begin
            ack_ff <= !sda;
          end else if (fall) begin
            if ((st_ff == I_AACK && rw_ff) || (st_ff == I_RACK && ack_ff)) begin
              oe_n_ff <= rd_b[7]; // R2 R3
              tx_ff <= {rd_b[6:0], 1'b1};
              ptr_ff <= 8'(ptr_ff + 1'b1); // R10
              cnt_ff <= '0;
              st_ff <= I_RDATA;
            end else begin
              oe_n_ff <= 1'b1;
              st_ff <= (st_ff == I_AACK) ? I_WDATA : I_IDLE;
            end
          end
        end
        I_RDATA: begin
          if (rise) begin
            cnt_ff <= 4'(cnt_ff + 1'b1);
          end else if (fall) begin
            if (cnt_ff == 4'h8) begin
              oe_n_ff <= 1'b1;
              cnt_ff <= '0;
              st_ff <= I_RACK;
            end else begin
              oe_n_ff <= tx_ff[7];
              tx_ff <= {tx_ff[6:0], 1'b1};
            end
          end
        end
        default: st_ff <= I_IDLE;
      endcase
    end
  end

  assign SDA_O = sda_o_ff;
  assign SDA_OE_N = oe_n_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  property p_hi_byte;
    !start && !stop && fall && st_ff == I_AACK && rw_ff && ptr_ff == `ALC_PTR_HI
      |=> oe_n_ff == $past(res_ff[15]) && ptr_ff == `ALC_PTR_LO;
  endproperty
  a_hi_byte: assert property (p_hi_byte) else $error("high byte not served"); // R2
  property p_lo_byte;
    !start && !stop && fall && st_ff == I_RACK && ack_ff && ptr_ff == `ALC_PTR_LO
      |=> oe_n_ff == lo_hold_ff[7];
  endproperty
  a_lo_byte: assert property (p_lo_byte) else $error("low byte not served"); // R3
  // the pointer moves only on a byte load or a pointer write, never while bits shift out
  property p_ptr_inc;
    st_ff == I_RDATA |=> ptr_ff == $past(ptr_ff);
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer moved mid byte"); // R10
  property p_load_inc;
    !start && !stop && fall && st_ff == I_AACK && rw_ff |=> ptr_ff == 8'($past(ptr_ff) + 1'b1);
  endproperty
  a_load_inc: assert property (p_load_inc) else $error("pointer did not advance"); // R10
  property p_restart;
    start |=> st_ff == I_ADDR && oe_n_ff && cnt_ff == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("start not taken"); // R11
  property p_stop;
    stop && !start |=> st_ff == I_IDLE && oe_n_ff;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken"); // R11
  c_lo_read: cover property (fall && st_ff == I_RACK && ack_ff && ptr_ff == `ALC_PTR_LO);
  c_rstart: cover property (start && st_ff == I_WDATA);
  c_cont: cover property (eng_res.valid && CONT_MODE);
endmodule

// *** bench/alc_host_model.sv ***
// serial bus host model that fetches the light result pair
// assumes a pull-up on the data wire, resolved by the bench
module alc_host_model (
  input logic clk,
  input logic sda,
  output logic scl,
  output logic sda_drv,
  output logic ev_stb,
  output logic [7:0] ev_val
);
  timeunit 1ns;
  timeprecision 1ns;
  // half bit period, well above the five cycles the slave needs
  localparam int HALF = 8;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    ev_stb = 1'b0;
    ev_val = 8'h00;
  end

  // ----------------------------------------
  // bit level
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // data moves two cycles after the clock fall, so no false start or stop
  task automatic bit_io(input logic b, output logic s);
    sda_drv <= b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    s = sda;
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic start_c();
    sda_drv <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_drv <= 1'b0;
    tick(HALF);
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic stop_c();
    sda_drv <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_drv <= 1'b1;
    tick(HALF);
  endtask

  // ----------------------------------------
  // byte level, each byte or ack reported once
  // ----------------------------------------
  task automatic emit(input logic [7:0] v);
    ev_val <= v;
    ev_stb <= 1'b1;
    tick(1);
    ev_stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    emit({7'h00, s});
  endtask

  task automatic rd(input logic nack);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(nack, s);
    emit(d);
  endtask

  task automatic read_result(input logic rep);
    start_c();
    wr(8'h26);
    wr(8'h85);
    if (!rep) stop_c();
    start_c();
    wr(8'h27);
    rd(1'b0);
    rd(1'b0);
    rd(1'b1);
    stop_c();
  endtask
endmodule

// *** bench/tb.sv ***
// testbench: result reads over the serial bus and conversion timing
// assumes alc_host_model as bus host and a shortened frame
`include "alc_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned FRAME = 13000;
  // run needs about 31000 cycles
  localparam int LIMIT = 50000;
  logic CLOCK, RST, CONT_MODE, SDA_O, SDA_OE_N, CONV_ACTIVE;
  logic scl, host_sda, sda_bus, ev_stb;
  logic [`ALC_AVG_W-1:0] AVG_CODE;
  logic [`ALC_RES_W-1:0] ALS_SAMPLE, smp, nx;
  logic [17:0] sum;
  logic [15:0] wid_ff;
  logic [7:0] ev_val;
  logic [7:0] eq[$];
  logic [15:0] wq[$];
  int failures = 0;
  int num_checks = 0;
  int cyc_ff = 0;

  // open drain wire with pull-up
  assign sda_bus = host_sda & (SDA_OE_N | SDA_O);

  alc_light_timing #(.FRAME_CYC(FRAME)) dut (
    .CLOCK(CLOCK), .RST(RST), .SCL_I(scl), .SDA_I(sda_bus), .SDA_O(SDA_O),
    .SDA_OE_N(SDA_OE_N), .CONT_MODE(CONT_MODE), .AVG_CODE(AVG_CODE),
    .ALS_SAMPLE(ALS_SAMPLE), .CONV_ACTIVE(CONV_ACTIVE));

  alc_host_model host (.clk(CLOCK), .sda(sda_bus), .scl(scl), .sda_drv(host_sda),
    .ev_stb(ev_stb), .ev_val(ev_val));

  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // three acks, high byte, low byte, then the unmapped next pointer
  task automatic fetch(input logic rep, input logic [15:0] v);
    repeat (3) eq.push_back(8'h00);
    eq.push_back(v[15:8]);
    eq.push_back(v[7:0]);
    eq.push_back(8'h00);
    host.read_result(rep);
  endtask

  always @(posedge CLOCK) begin
    cyc_ff <= cyc_ff + 1;
    if (cyc_ff == LIMIT) begin
      failures = failures + 1;
      print_verdict();
    end
  end

  always @(posedge CLOCK) begin
    if (ev_stb === 1'b1) check("read byte", {8'h00, ev_val}, {8'h00, eq.pop_front()});
  end

  // only batches with a noted width are compared
  always @(posedge CLOCK) begin
    if (CONV_ACTIVE === 1'b1) wid_ff <= wid_ff + 16'h0001;
    else begin
      if (wid_ff != 16'h0000 && wq.size() > 0) check("batch width", wid_ff, wq.pop_front());
      wid_ff <= 16'h0000;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    RST = 1'b1;
    CONT_MODE = 1'b0;
    AVG_CODE = 3'h0;
    ALS_SAMPLE = 16'h0000;
    wid_ff = 16'h0000;
    sum = 18'h00000;
    void'($urandom(55586));
    smp = $urandom;
    wq.push_back(16'(`ALC_CONV_CYC));
    repeat (6) @(posedge CLOCK);
    RST <= 1'b0;
    ALS_SAMPLE <= smp;
    @(negedge CONV_ACTIVE);
    AVG_CODE <= 3'h2;
    fetch(1'b0, 16'h0000);
    @(posedge CONV_ACTIVE);
    wq.push_back(16'(`ALC_CONV_CYC << 2));
    fork
      fetch(1'b0, smp);
      begin
        // new sample mid-way through each of the four conversions
        repeat (1499) @(posedge CLOCK);
        for (int k = 0; k < 4; k++) begin
          nx = $urandom;
          sum = sum + 18'(nx);
          ALS_SAMPLE <= nx;
          if (k < 3) repeat (3000) @(posedge CLOCK);
        end
      end
    join
    // batch done but frame still open: the old result must still show
    repeat (1600) @(posedge CLOCK);
    CONT_MODE <= 1'b1;
    AVG_CODE <= 3'h0;
    fetch(1'b1, smp);
    smp = $urandom;
    ALS_SAMPLE <= smp;
    fetch(1'b1, sum[17:2]);
    // far inside the frame, so only a continuous publish can show smp
    repeat (2100) @(posedge CLOCK);
    fetch(1'b1, smp);
    repeat (20) @(posedge CLOCK);
    check("pending reads", 16'(eq.size()), 16'h0000);
    print_verdict();
  end
endmodule
